// *** core/pst_consts.vh ***
`ifndef PST_CONSTS_VH
`define PST_CONSTS_VH

`define PST_PC_W        13
`define PST_RESET_VEC   13'h0000
`define PST_ONE         13'h0001
`define PST_MASK_4K     13'h0fff
`define PST_MASK_8K     13'h1fff
`define PST_PAGE_HI     12
`define PST_PAGE_LO     8

`define PST_OP_W        4
`define PST_OP_NONE     4'h0
`define PST_OP_JUMP     4'h1
`define PST_OP_CALL     4'h2
`define PST_OP_RET      4'h3
`define PST_OP_INTERRUPT_RETURN_OP     4'h4
`define PST_OP_SKIP     4'h5
`define PST_OP_TRD      4'h6
`define PST_OP_TRDL     4'h7
`define PST_OP_LTRD     4'h8
`define PST_OP_LTRDL    4'h9

`define PST_STACK_DEPTH 4'h8
`define PST_SP_W        3

`define PST_PH_T1       2'h0
`define PST_PH_T2       2'h1
`define PST_PH_T4       2'h3

`define PST_ADDR_W      12
`define PST_OFF_PCL     12'h000
`define PST_OFF_TBLP    12'h004
`define PST_OFF_TABLE_POINTER_HIGH    12'h008
`define PST_OFF_TABLE_HIGH_RESULT    12'h00c
`define PST_OFF_STATUS  12'h010

`define PST_TABLE_HIGH_RESULT_MASK   8'hff
`define PST_STATUS_RST  8'h00

`endif

// *** core/pst_phase.v ***
`default_nettype none
`include "pst_consts.vh"
module pst_phase (
	input  wire       pclk,
	input  wire       presetn,
	output wire [1:0] phase
);
	reg [1:0] phase_reg;

	// Four non-overlapping phases per instruction cycle; T1 follows reset.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= `PST_PH_T1;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end

	assign phase = phase_reg;
endmodule
`default_nettype wire

// *** core/pst_stack.v ***
`default_nettype none
`include "pst_consts.vh"
module pst_stack (
	input  wire                 pclk,
	input  wire                 presetn,
	input  wire                 push,
	input  wire                 pop,
	input  wire [`PST_PC_W-1:0] push_data,
	output wire [`PST_PC_W-1:0] top_data,
	output wire                 full
);
	reg [`PST_PC_W-1:0] entry_reg [0:7];
	reg [`PST_SP_W-1:0] ptr_reg;
	reg [3:0]           count_reg;
	genvar              i;

	// The pointer wraps, so a push while full overwrites the oldest entry.
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_entry
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					entry_reg[i] <= `PST_RESET_VEC;
				end else if (push && ptr_reg == i) begin
					entry_reg[i] <= push_data;
				end
			end
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_reg   <= {`PST_SP_W{1'b0}};
			count_reg <= 4'h0;
		end else if (push) begin
			ptr_reg <= ptr_reg + 3'h1;
			if (count_reg != `PST_STACK_DEPTH) begin
				count_reg <= count_reg + 4'h1;
			end
		end else if (pop) begin
			ptr_reg <= ptr_reg - 3'h1;
			if (count_reg != 4'h0) begin
				count_reg <= count_reg - 4'h1;
			end
		end
	end

	assign top_data = entry_reg[ptr_reg - 3'h1];
	assign full     = (count_reg == `PST_STACK_DEPTH);
endmodule
`default_nettype wire

// *** core/pst_sequencer.v ***
`default_nettype none
`include "pst_consts.vh"
module pst_sequencer (
	input  wire                  pclk,
	input  wire                  presetn,
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [31:0]           paddr,
	input  wire [31:0]           pwdata,
	output wire [31:0]           prdata,
	output wire                  pready,
	output wire                  pslverr,
	input  wire [`PST_OP_W-1:0]  op_kind,
	input  wire [`PST_PC_W-1:0]  op_target,
	input  wire [7:0]            op_dest,
	input  wire [2:0]            op_sector,
	input  wire [2:0]            cur_sector,
	input  wire                  int_req,
	input  wire [`PST_PC_W-1:0]  int_vector,
	input  wire                  alu_flag_we,
	input  wire [7:0]            alu_flags,
	input  wire                  mem_8k,
	input  wire [15:0]           prog_rdata,
	output wire [`PST_PC_W-1:0]  prog_addr,
	output wire                  prog_rd,
	output wire                  exec_valid,
	output wire                  int_ack,
	output wire                  dm_we,
	output wire [7:0]            dm_addr,
	output wire [2:0]            dm_sector,
	output wire [7:0]            dm_wdata,
	output wire [7:0]            status_flags
);
	localparam ST_EXEC  = 2'h0;
	localparam ST_DUMMY = 2'h1;
	localparam ST_TABLE = 2'h2;
	wire [1:0]            phase;
	wire [`PST_PC_W-1:0]  stack_top;
	wire                  stack_full;
	reg                   stack_push;
	reg                   stack_pop;
	reg  [`PST_PC_W-1:0]  stack_din;
	reg  [1:0]            state_reg;
	reg  [1:0]            state_next;
	reg  [`PST_PC_W-1:0]  pc_reg;
	reg  [`PST_PC_W-1:0]  pc_next;
	reg  [`PST_PC_W-1:0]  tbl_addr_reg;
	reg  [`PST_PC_W-1:0]  tbl_addr_next;
	reg  [7:0]            tbl_dest_reg;
	reg  [7:0]            tbl_dest_next;
	reg  [2:0]            tbl_sector_reg;
	reg  [2:0]            tbl_sector_next;
	reg  [`PST_PC_W-1:0]  prog_addr_reg;
	reg  [`PST_PC_W-1:0]  prog_addr_next;
	reg                   prog_rd_reg;
	reg                   prog_rd_next;
	reg                   exec_valid_reg;
	reg                   exec_valid_next;
	reg                   int_pend_reg;
	reg                   int_take;
	reg                   int_ack_reg;
	reg                   pcl_pend_reg;
	reg  [7:0]            pcl_val_reg;
	reg                   pcl_take;
	reg                   dm_we_reg;
	reg                   dm_we_next;
	reg  [7:0]            dm_addr_reg;
	reg  [2:0]            dm_sector_reg;
	reg  [7:0]            dm_wdata_reg;
	reg  [7:0]            tblp_reg;
	reg  [4:0]            table_pointer_high_reg;
	reg  [7:0]            table_high_result_reg;
	reg  [7:0]            status_reg;
	reg                   size_meta_reg;
	reg                   size_sync_reg;
	reg  [31:0]           prdata_reg;
	reg                   pready_reg;
	reg                   pslverr_reg;
	wire [`PST_PC_W-1:0]  pc_mask;
	wire                  t1;
	wire                  t2;
	wire                  t4;
	wire                  apb_setup;
	wire                  apb_wr;

	// Keeps every program address inside the selected variant's space.
	function [`PST_PC_W-1:0] wrap;
		input [`PST_PC_W-1:0] a;
		input [`PST_PC_W-1:0] m;
		begin
			wrap = a & m;
		end
	endfunction

	// Byte offsets of the register window; anything else is an error.
	function hit;
		input [31:0] a;
		begin
			hit = (a[`PST_ADDR_W-1:0] == `PST_OFF_PCL) ||
				(a[`PST_ADDR_W-1:0] == `PST_OFF_TBLP) ||
				(a[`PST_ADDR_W-1:0] == `PST_OFF_TABLE_POINTER_HIGH) ||
				(a[`PST_ADDR_W-1:0] == `PST_OFF_TABLE_HIGH_RESULT) ||
				(a[`PST_ADDR_W-1:0] == `PST_OFF_STATUS);
			hit = hit && (a[31:`PST_ADDR_W] == 20'h00000);
		end
	endfunction

	pst_phase u_phase (
		.pclk    (pclk),
		.presetn (presetn),
		.phase   (phase)
	);

	pst_stack u_stack (
		.pclk      (pclk),
		.presetn   (presetn),
		.push      (stack_push),
		.pop       (stack_pop),
		.push_data (stack_din),
		.top_data  (stack_top),
		.full      (stack_full)
	);

	assign t1        = (phase == `PST_PH_T1);
	assign t2        = (phase == `PST_PH_T2);
	assign t4        = (phase == `PST_PH_T4);
	assign pc_mask   = size_sync_reg ? `PST_MASK_8K : `PST_MASK_4K;
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite && pready_reg;

	// The size strap is a pin, so it is synchronised before use.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			size_meta_reg <= 1'b0;
			size_sync_reg <= 1'b0;
		end else begin
			size_meta_reg <= mem_8k;
			size_sync_reg <= size_meta_reg;
		end
	end

	always @* begin
		state_next      = state_reg;
		pc_next         = pc_reg;
		tbl_addr_next   = tbl_addr_reg;
		tbl_dest_next   = tbl_dest_reg;
		tbl_sector_next = tbl_sector_reg;
		prog_addr_next  = prog_addr_reg;
		prog_rd_next    = 1'b0;
		exec_valid_next = exec_valid_reg;
		dm_we_next      = 1'b0;
		stack_push      = 1'b0;
		stack_pop       = 1'b0;
		stack_din       = pc_reg;
		int_take        = 1'b0;
		pcl_take        = 1'b0;
		// A table cycle holds the counter so the prefetched word is kept.
		if (t1 && state_reg != ST_TABLE) begin
			prog_addr_next = pc_reg;
			prog_rd_next   = 1'b1;
			pc_next        = wrap(pc_reg + `PST_ONE, pc_mask);
		end
		if (t1) begin
			exec_valid_next = (state_reg == ST_EXEC);
		end
		if (t2 && state_reg == ST_TABLE) begin
			prog_addr_next = tbl_addr_reg;
			prog_rd_next   = 1'b1;
		end
		if (t4) begin
			case (state_reg)
				ST_EXEC: begin
					case (op_kind)
						`PST_OP_JUMP: begin
							pc_next    = wrap(op_target, pc_mask);
							state_next = ST_DUMMY;
						end
						`PST_OP_CALL: begin
							stack_push = 1'b1;
							pc_next    = wrap(op_target, pc_mask);
							state_next = ST_DUMMY;
						end
						`PST_OP_RET, `PST_OP_INTERRUPT_RETURN_OP: begin
							stack_pop  = 1'b1;
							pc_next    = wrap(stack_top, pc_mask);
							state_next = ST_DUMMY;
						end
						`PST_OP_SKIP: begin
							state_next = ST_DUMMY;
						end
						`PST_OP_TRD, `PST_OP_LTRD: begin
							tbl_addr_next = wrap({pc_reg[`PST_PAGE_HI:`PST_PAGE_LO],
								tblp_reg}, pc_mask);
							state_next = ST_TABLE;
						end
						`PST_OP_TRDL, `PST_OP_LTRDL: begin
							tbl_addr_next = wrap({table_pointer_high_reg, tblp_reg}, pc_mask);
							state_next = ST_TABLE;
						end
						default: begin
							if (pcl_pend_reg) begin
								pcl_take   = 1'b1;
								pc_next    = {pc_reg[`PST_PAGE_HI:`PST_PAGE_LO],
									pcl_val_reg};
								state_next = ST_DUMMY;
							end else if (int_pend_reg && !stack_full) begin
								int_take   = 1'b1;
								stack_push = 1'b1;
								stack_din  = wrap(pc_reg - `PST_ONE, pc_mask);
								pc_next    = wrap(int_vector, pc_mask);
								state_next = ST_DUMMY;
							end
						end
					endcase
					tbl_dest_next   = op_dest;
					tbl_sector_next = (op_kind == `PST_OP_LTRD ||
						op_kind == `PST_OP_LTRDL) ? op_sector : cur_sector;
				end
				ST_TABLE: begin
					dm_we_next = 1'b1;
					state_next = ST_EXEC;
				end
				default: begin
					state_next = ST_EXEC;
				end
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= ST_EXEC;
			pc_reg         <= `PST_RESET_VEC;
			prog_addr_reg  <= `PST_RESET_VEC;
			prog_rd_reg    <= 1'b0;
			exec_valid_reg <= 1'b0;
			tbl_addr_reg   <= `PST_RESET_VEC;
			tbl_dest_reg   <= 8'h00;
			tbl_sector_reg <= 3'h0;
			int_ack_reg    <= 1'b0;
			dm_we_reg      <= 1'b0;
		end else begin
			state_reg      <= state_next;
			pc_reg         <= pc_next;
			prog_addr_reg  <= prog_addr_next;
			prog_rd_reg    <= prog_rd_next;
			exec_valid_reg <= exec_valid_next;
			tbl_addr_reg   <= tbl_addr_next;
			tbl_dest_reg   <= tbl_dest_next;
			tbl_sector_reg <= tbl_sector_next;
			int_ack_reg    <= int_take;
			dm_we_reg      <= dm_we_next;
		end
	end

	// A request arriving as the pending one is taken stays pending.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_pend_reg <= 1'b0;
			pcl_pend_reg <= 1'b0;
			pcl_val_reg  <= 8'h00;
		end else begin
			int_pend_reg <= int_req || (int_pend_reg && !int_take);
			if (apb_wr && paddr[`PST_ADDR_W-1:0] == `PST_OFF_PCL && hit(paddr)) begin
				pcl_pend_reg <= 1'b1;
				pcl_val_reg  <= pwdata[7:0];
			end else if (pcl_take) begin
				pcl_pend_reg <= 1'b0;
			end
		end
	end

	// Table result and data write; only a table read changes the high result.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			table_high_result_reg      <= 8'h00;
			dm_addr_reg   <= 8'h00;
			dm_sector_reg <= 3'h0;
			dm_wdata_reg  <= 8'h00;
		end else if (dm_we_next) begin
			table_high_result_reg      <= prog_rdata[15:8] & `PST_TABLE_HIGH_RESULT_MASK;
			dm_addr_reg   <= tbl_dest_reg;
			dm_sector_reg <= tbl_sector_reg;
			dm_wdata_reg  <= prog_rdata[7:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tblp_reg   <= 8'h00;
			table_pointer_high_reg   <= 5'h00;
			status_reg <= `PST_STATUS_RST;
		end else begin
			if (alu_flag_we) begin
				status_reg <= alu_flags;
			end
			if (apb_wr && paddr[`PST_ADDR_W-1:0] == `PST_OFF_TBLP && hit(paddr)) begin
				tblp_reg <= pwdata[7:0];
			end
			if (apb_wr && paddr[`PST_ADDR_W-1:0] == `PST_OFF_TABLE_POINTER_HIGH && hit(paddr)) begin
				table_pointer_high_reg <= pwdata[4:0];
			end
		end
	end

	// One wait-free access cycle: data is prepared during setup.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= apb_setup;
			pslverr_reg <= apb_setup && !hit(paddr);
			if (apb_setup && !pwrite) begin
				case (paddr[`PST_ADDR_W-1:0])
					`PST_OFF_PCL:    prdata_reg <= {24'h000000, pc_reg[7:0]};
					`PST_OFF_TBLP:   prdata_reg <= {24'h000000, tblp_reg};
					`PST_OFF_TABLE_POINTER_HIGH:   prdata_reg <= {27'h0000000, table_pointer_high_reg};
					`PST_OFF_TABLE_HIGH_RESULT:   prdata_reg <= {24'h000000, table_high_result_reg};
					`PST_OFF_STATUS: prdata_reg <= {24'h000000, status_reg};
					default:         prdata_reg <= 32'h00000000;
				endcase
				if (!hit(paddr)) begin
					prdata_reg <= 32'h00000000;
				end
			end
		end
	end

	assign prdata       = prdata_reg;
	assign pready       = pready_reg;
	assign pslverr      = pslverr_reg;
	assign prog_addr    = prog_addr_reg;
	assign prog_rd      = prog_rd_reg;
	assign exec_valid   = exec_valid_reg;
	assign int_ack      = int_ack_reg;
	assign dm_we        = dm_we_reg;
	assign dm_addr      = dm_addr_reg;
	assign dm_sector    = dm_sector_reg;
	assign dm_wdata     = dm_wdata_reg;
	assign status_flags = status_reg;
endmodule
`default_nettype wire

// *** testbench/pst_prog_rom.sv ***
`default_nettype none
`include "pst_consts.vh"
module pst_prog_rom (
	input  wire logic [`PST_PC_W-1:0] prog_addr,
	output wire logic [15:0]          prog_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// The word mixes page and offset bits, so a wrong page or offset shows in either byte.
	assign prog_rdata = {prog_addr[12:5], prog_addr[7:0] ^ 8'h5a};
endmodule
`default_nettype wire

// *** testbench/pst_sequencer_asserts.sv ***
`default_nettype none
`include "pst_consts.vh"
module pst_seq_chk (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic [31:0]          paddr,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic [`PST_OP_W-1:0] op_kind,
	input wire logic [`PST_PC_W-1:0] op_target,
	input wire logic [7:0]           op_dest,
	input wire logic                 exec_valid,
	input wire logic                 int_ack,
	input wire logic [`PST_PC_W-1:0] int_vector,
	input wire logic                 alu_flag_we,
	input wire logic [7:0]           alu_flags,
	input wire logic [7:0]           status_flags,
	input wire logic                 prog_rd,
	input wire logic [`PST_PC_W-1:0] prog_addr,
	input wire logic                 dm_we,
	input wire logic [7:0]           dm_addr,
	input wire logic                 mem_8k
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph;
	logic [7:0] tdest;
	logic       t4;
	logic       size_meta;
	logic       size_sync;
	// The size strap is mirrored through two flops so the expected target follows the core.
	// Phase is rebuilt from reset, since the core does not export it.
	assign t4 = ph == 2'h3 && exec_valid;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph <= 2'h0;
			tdest <= 8'h00;
			size_meta <= 1'b0;
			size_sync <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			size_meta <= mem_8k;
			size_sync <= size_meta;
			if (t4 && op_kind >= `PST_OP_TRD && op_kind <= `PST_OP_LTRDL) begin
				tdest <= op_dest;
			end
		end
	end
	default clocking dclk @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_APB_READY: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_UNMAPPED: assert property (psel && !penable && paddr[11:0] > 12'h010 |=> pslverr)
		else $error("no error on unmapped offset");
	AST_RESET_FETCH: assert property ($rose(presetn) |=> prog_rd && prog_addr == 13'h0000)
		else $error("first fetch not at zero");
	AST_BRANCH_LOAD: assert property (t4 &&
		(op_kind == `PST_OP_JUMP || op_kind == `PST_OP_CALL) |-> ##2 (!exec_valid && prog_rd &&
		prog_addr == {$past(size_sync, 2) && $past(op_target[12], 2), $past(op_target[11:0], 2)}))
		else $error("branch target not fetched after dummy");
	AST_SKIP_DUMMY: assert property (t4 && op_kind == `PST_OP_SKIP |-> ##2 !exec_valid)
		else $error("taken skip without dummy cycle");
	AST_STATUS_UPD: assert property (alu_flag_we |=> status_flags == $past(alu_flags))
		else $error("status flags not updated");
	AST_TABLE_WE: assert property (t4 &&
		op_kind >= `PST_OP_TRD && op_kind <= `PST_OP_LTRDL
		|-> ##[4:6] (dm_we && dm_addr == tdest))
		else $error("table write late or wrong");
	AST_INT_LOAD: assert property (int_ack |-> ##[1:6] (prog_rd && prog_addr == int_vector))
		else $error("interrupt vector not fetched");
endmodule
bind pst_sequencer pst_seq_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready,
	.pslverr, .op_kind, .op_target, .op_dest, .exec_valid, .int_ack, .int_vector,
	.alu_flag_we, .alu_flags, .status_flags, .prog_rd, .prog_addr, .dm_we, .dm_addr, .mem_8k);
`default_nettype wire

// *** testbench/tb_pst_sequencer.sv ***
`default_nettype none
`include "pst_consts.vh"
module tb_pst_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  op_kind = 4'h0;
	logic [12:0] op_target = 13'h0;
	logic [7:0]  op_dest = 8'h0;
	logic        int_req = 1'b0;
	logic        alu_flag_we = 1'b0;
	logic        mem_8k = 1'b1;
	logic [7:0]  alu_flags = 8'h0;
	wire [31:0]  prdata;
	wire         pready, pslverr, prog_rd, exec_valid, int_ack, dm_we;
	wire [15:0]  prog_rdata;
	wire [12:0]  prog_addr;
	wire [7:0]   dm_addr, dm_wdata, status_flags;
	wire [2:0]   dm_sector;
	logic [1:0]  ph;
	logic [12:0] a, b, ta;
	logic [31:0] rd;
	logic        er, ev;
	logic [3:0]  k;
	int          err_count = 0;
	int          tests_run = 0;
	int          i, n;
	always #12.5 pclk = ~pclk;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) ph <= 2'h0;
		else ph <= ph + 2'h1;
	end
	pst_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .op_kind, .op_target, .op_dest, .op_sector(3'h5), .cur_sector(3'h2),
		.int_req, .int_vector(13'h0155), .alu_flag_we, .alu_flags, .mem_8k, .prog_rdata,
		.prog_addr, .prog_rd, .exec_valid, .int_ack, .dm_we, .dm_addr, .dm_sector, .dm_wdata,
		.status_flags);
	pst_prog_rom u_rom (.prog_addr, .prog_rdata);
	function automatic logic [15:0] word(input logic [12:0] x);
		word = {x[12:5], x[7:0] ^ 8'h5a};
	endfunction
	task report_and_stop;
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task hang(input string nm);
		err_count++;
		$display("[FAIL] %s expected answer seen timeout", nm);
		report_and_stop;
	endtask
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int j;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {20'h0, ad};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (j = 0; j < 8; j++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (j == 8) hang("pready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task fetch(output logic [12:0] x);
		int j;
		for (j = 0; j < 16; j++) begin
			@(posedge pclk);
			if (prog_rd === 1'b1) break;
		end
		if (j == 16) hang("fetch");
		x = prog_addr;
		ev = exec_valid;
	endtask
	// Ops are offered only at the fourth phase of a live cycle, the sole moment they count.
	task issue(input logic [3:0] op, input logic [12:0] t);
		int j;
		for (j = 0; j < 16; j++) begin
			@(posedge pclk);
			if (ph == 2'h2 && exec_valid === 1'b1) break;
		end
		if (j == 16) hang("issue");
		op_kind <= op;
		op_target <= t;
		op_dest <= {4'h8, op};
		@(posedge pclk);
		op_kind <= 4'h0;
	endtask
	task br(input logic [3:0] op, input logic [12:0] t, input logic [12:0] e);
		issue(op, t);
		fetch(b);
		chk("dummy valid", 32'h0, {31'h0, ev});
		chk("branch fetch", e, b);
		fetch(b);
		chk("step fetch", e + 13'h1, b);
	endtask
	task acks(input int c);
		n = 0;
		for (i = 0; i < c; i++) begin
			@(posedge pclk);
			if (int_ack === 1'b1) n++;
		end
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		fetch(a);
		chk("reset fetch", 32'h0, a);
		fetch(a);
		chk("next fetch", 32'h1, a);
		br(`PST_OP_JUMP, 13'h0a00, 13'h0a00);
		apb(1'b1, 12'h004, 32'h06);
		apb(1'b1, 12'h008, 32'h0f);
		for (k = 4'h6; k <= 4'h9; k++) begin
			issue(k, 13'h0);
			ta = k[0] ? 13'h0f06 : 13'h0a06;
			for (i = 0; i < 16 && dm_we !== 1'b1; i++) @(posedge pclk);
			if (i == 16) hang("table write");
			chk("table low", word(ta) & 16'h00ff, dm_wdata);
			chk("table dest", {4'h8, k}, dm_addr);
			chk("table sector", k >= 4'h8 ? 3'h5 : 3'h2, dm_sector);
			apb(1'b1, 12'h00c, 32'hff);
			apb(1'b0, 12'h00c, 32'h0);
			chk("table high", word(ta) >> 8, rd);
		end
		fetch(a);
		br(`PST_OP_SKIP, 13'h0, a + 13'h1);
		fetch(a);
		br(`PST_OP_CALL, 13'h0300, 13'h0300);
		br(`PST_OP_RET, 13'h0, a + 13'h1);
		apb(1'b1, 12'h000, 32'hf0);
		n = 0;
		for (i = 0; i < 48 && n == 0; i++) begin
			@(posedge pclk);
			if (prog_rd === 1'b1 && prog_addr === 13'h0af0) n = 1;
		end
		chk("low byte branch", 32'h1, n);
		apb(1'b0, 12'h014, 32'h0);
		chk("unmapped error", 32'h1, er);
		chk("unmapped data", 32'h0, rd);
		apb(1'b0, 12'h000, 32'h0);
		chk("low byte upper", 32'h0, rd >> 8);
		@(posedge pclk);
		alu_flag_we <= 1'b1;
		alu_flags <= 8'ha6;
		@(posedge pclk);
		alu_flag_we <= 1'b0;
		apb(1'b1, 12'h010, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk("status", 32'ha6, rd);
		for (k = 4'h0; k < 4'h8; k++) issue(`PST_OP_CALL, 13'h0400);
		br(`PST_OP_CALL, 13'h0400, 13'h0400);
		int_req <= 1'b1;
		@(posedge pclk);
		int_req <= 1'b0;
		acks(24);
		chk("ack while full", 32'h0, n);
		issue(`PST_OP_RET, 13'h0);
		acks(24);
		chk("ack after return", 32'h1, n);
		mem_8k <= 1'b0;
		repeat (3) @(posedge pclk);
		br(`PST_OP_JUMP, 13'h1b00, 13'h0b00);
		// The stack is full here, so an acknowledge after reset proves the entry count was cleared.
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		fetch(a);
		chk("reset fetch again", 32'h0, a);
		int_req <= 1'b1;
		@(posedge pclk);
		int_req <= 1'b0;
		acks(24);
		chk("ack after reset", 32'h1, n);
		report_and_stop;
	end
endmodule
`default_nettype wire
